// [hw/hrp_cs_decoder.sv]
// Companion chip select decoder driven by the latched top address bits.
`default_nettype none
module hrp_cs_decoder #(
  parameter int NUM_COMP = hrp_pkg::NUM_COMPANIONS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoder inputs
  input wire logic chip_sel_n,
  input wire logic [2:0] addr_top,
  // Companion selects
  output logic [NUM_COMP-1:0] companion_cs_n
);
  // ****************************************************************
  // One registered select per companion
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < NUM_COMP; i++)
    begin : g_comp
      wire logic hit;
      assign hit = !chip_sel_n &&
                   (addr_top == 3'(i + 1) || addr_top == hrp_pkg::TOP_ALL);
      always_ff @(posedge clk)
      begin
        if (rst)
          companion_cs_n[i] <= 1'b1;
        else
          companion_cs_n[i] <= !hit;
      end
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_cs_broadcast: assert property (@(posedge clk) disable iff (rst)
    !chip_sel_n && addr_top == hrp_pkg::TOP_ALL |=> companion_cs_n == '0)
    else $error("broadcast did not select every companion");
  a_cs_reserved: assert property (@(posedge clk) disable iff (rst)
    (chip_sel_n || addr_top == hrp_pkg::TOP_NONE || addr_top == hrp_pkg::TOP_SELF)
    |=> companion_cs_n == '1)
    else $error("companion selected for self, reserved or idle address");
  a_cs_single: assert property (@(posedge clk) disable iff (rst)
    !chip_sel_n && addr_top == 3'h3 |=> companion_cs_n == 5'h1B)
    else $error("wrong companion selected for top address three");
endmodule
`default_nettype wire

// [hw/hrp_host_port.sv]
// Parallel host register port: bus style select, address latch, access sequencer.
`default_nettype none
module hrp_host_port #(
  parameter int NUM_COMP = hrp_pkg::NUM_COMPANIONS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus style straps
  input wire logic [2:0] host_style_select,
  // Host address and control
  input wire logic [10:0] addr_in,
  input wire logic address_latch_strobe,
  input wire logic chip_sel_n,
  input wire logic rd_strobe_n,
  input wire logic wr_dir,
  input wire logic sync_clk_in,
  // Host data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Host handshake and interrupt
  output logic cycle_done_n,
  output logic host_irq_n,
  // Companion selects
  output logic [NUM_COMP-1:0] companion_cs_n,
  // Core side
  input wire logic [7:0] status_in,
  output logic cfg_wr_pulse,
  output logic [7:0] cfg_wr_addr,
  output logic [7:0] cfg_wr_data
);
  // ****************************************************************
  // Strap capture and style decode
  // ****************************************************************
  logic [2:0] style_reg;
  logic style_cap_reg;
  // The straps are static, so sampling once after reset release is enough.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      style_reg <= hrp_pkg::TOP_NONE;
      style_cap_reg <= 1'b0;
    end
    else if (!style_cap_reg)
    begin
      style_reg <= host_style_select;
      style_cap_reg <= 1'b1;
    end
  end

  wire logic style_latch;
  wire logic style_dir;
  wire logic style_sync;
  wire logic style_ok;
  assign style_latch = style_cap_reg && style_reg == hrp_pkg::STYLE_LATCH;
  assign style_dir = style_cap_reg && style_reg == hrp_pkg::STYLE_DIR;
  assign style_sync = style_cap_reg && style_reg == hrp_pkg::STYLE_SYNC;
  // Undefined strap patterns keep the sequencer from starting any access; the address latch and companion selects still follow the host.
  assign style_ok = style_latch || style_dir || style_sync;

  // ****************************************************************
  // Control pin meaning per style
  // ****************************************************************
  wire logic rd_req;
  wire logic wr_req;
  assign rd_req = style_latch ? !rd_strobe_n : (!rd_strobe_n && wr_dir);
  assign wr_req = style_latch ? !wr_dir : (!rd_strobe_n && !wr_dir);

  logic sync_clk_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      sync_clk_q <= 1'b0;
    else
      sync_clk_q <= sync_clk_in;
  end
  wire logic sync_rise;
  assign sync_rise = sync_clk_in && !sync_clk_q;

  // ****************************************************************
  // Address latch
  // ****************************************************************
  logic [2:0] addr_top_reg;
  logic [7:0] addr_low_reg;
  // Transparent while the strobe is high, so a strobe tied high still works.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_top_reg <= hrp_pkg::ADDR_TOP_RESET;
      addr_low_reg <= hrp_pkg::ADDR_LOW_RESET;
    end
    else if (address_latch_strobe)
    begin
      addr_top_reg <= addr_in[10:8];
      addr_low_reg <= addr_in[7:0];
    end
  end

  hrp_cs_decoder #(
    .NUM_COMP(NUM_COMP)
  ) u_cs_decoder (
    .clk(clk),
    .rst(rst),
    .chip_sel_n(chip_sel_n),
    .addr_top(addr_top_reg),
    .companion_cs_n(companion_cs_n)
  );

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  hrp_pkg::hrp_state_e state_reg;
  hrp_pkg::hrp_state_e state_next;
  logic is_read_reg;
  logic [7:0] regs_mem [hrp_pkg::NUM_REGS];

  wire logic self_sel;
  wire logic start;
  wire logic release_bus;
  // A broadcast read would make every device drive the bus, so it is ignored.
  assign self_sel = addr_top_reg == hrp_pkg::TOP_SELF ||
                    (addr_top_reg == hrp_pkg::TOP_ALL && !rd_req);
  assign start = state_reg == hrp_pkg::HRP_IDLE && !chip_sel_n && style_ok && self_sel &&
                 (rd_req || wr_req) && (!style_sync || sync_rise);
  assign release_bus = chip_sel_n || !(rd_req || wr_req);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      hrp_pkg::HRP_IDLE:
        if (start)
          state_next = hrp_pkg::HRP_ACCESS;
      hrp_pkg::HRP_ACCESS:
        state_next = release_bus ? hrp_pkg::HRP_IDLE : hrp_pkg::HRP_HOLD;
      hrp_pkg::HRP_HOLD:
        if (release_bus)
          state_next = hrp_pkg::HRP_IDLE;
      default:
        state_next = hrp_pkg::HRP_IDLE;
    endcase
  end

  wire logic do_write;
  wire logic [7:0] rd_value;
  assign do_write = start && !rd_req;
  assign rd_value = addr_low_reg == hrp_pkg::STATUS_ADDR ? status_in :
                    regs_mem[addr_low_reg];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= hrp_pkg::HRP_IDLE;
      is_read_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (start)
        is_read_reg <= rd_req;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < hrp_pkg::NUM_REGS; k++)
        regs_mem[k] <= hrp_pkg::REG_RESET;
    end
    else if (do_write)
      regs_mem[addr_low_reg] <= data_in;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_out <= 8'h00;
      cfg_wr_pulse <= 1'b0;
      cfg_wr_addr <= 8'h00;
      cfg_wr_data <= 8'h00;
      host_irq_n <= 1'b1;
    end
    else
    begin
      if (state_reg == hrp_pkg::HRP_ACCESS && is_read_reg)
        data_out <= rd_value;
      cfg_wr_pulse <= do_write;
      if (do_write)
      begin
        cfg_wr_addr <= addr_low_reg;
        cfg_wr_data <= data_in;
      end
      host_irq_n <= !(|status_in);
    end
  end

  assign cycle_done_n = state_reg != hrp_pkg::HRP_HOLD;
  assign data_oe = state_reg == hrp_pkg::HRP_HOLD && is_read_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_read_start;
    start && rd_req;
  endsequence
  sequence s_held_selected;
    !chip_sel_n && rd_req;
  endsequence

  a_read_ready: assert property (@(posedge clk) disable iff (rst)
    s_read_start ##1 s_held_selected |=> !cycle_done_n && data_oe)
    else $error("ready or data drive missing two cycles after read start");
  a_read_data: assert property (@(posedge clk) disable iff (rst)
    s_read_start ##1 s_held_selected |=> data_out == $past(rd_value))
    else $error("read data does not match addressed register");
  a_oe_quiet: assert property (@(posedge clk) disable iff (rst)
    $past(chip_sel_n) || !is_read_reg |-> !data_oe)
    else $error("data bus driven outside a selected read");
  a_cs_gate: assert property (@(posedge clk) disable iff (rst)
    chip_sel_n && state_reg == hrp_pkg::HRP_IDLE |=> state_reg == hrp_pkg::HRP_IDLE)
    else $error("access began without chip select");
  a_write_store: assert property (@(posedge clk) disable iff (rst)
    do_write |=> regs_mem[$past(addr_low_reg)] == $past(data_in) && cfg_wr_pulse)
    else $error("write not stored at latched address");
  a_addr_hold: assert property (@(posedge clk) disable iff (rst)
    !address_latch_strobe |=> $stable(addr_low_reg) && $stable(addr_top_reg))
    else $error("address changed while latch strobe low");
  a_style_static: assert property (@(posedge clk) disable iff (rst)
    style_cap_reg |=> $stable(style_reg))
    else $error("bus style changed after capture");
  a_dir_write: assert property (@(posedge clk) disable iff (rst)
    start && style_dir && !wr_dir |=> !is_read_reg)
    else $error("direction low not taken as write");
  a_latch_read: assert property (@(posedge clk) disable iff (rst)
    start && style_latch && !rd_strobe_n |=> is_read_reg)
    else $error("read strobe not taken as read in latch style");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    |status_in |=> !host_irq_n)
    else $error("interrupt not raised for pending status");
endmodule
`default_nettype wire

// [hw/hrp_pkg.sv]
// Package of constants and types shared by the host register port.
`default_nettype none
package hrp_pkg;
  // ****************************************************************
  // Bus style straps
  // ****************************************************************
  localparam logic [2:0] STYLE_LATCH = 3'h0;
  localparam logic [2:0] STYLE_DIR = 3'h1;
  localparam logic [2:0] STYLE_SYNC = 3'h7;

  // ****************************************************************
  // Top address decoding
  // ****************************************************************
  localparam logic [2:0] TOP_SELF = 3'h0;
  localparam logic [2:0] TOP_NONE = 3'h6;
  localparam logic [2:0] TOP_ALL = 3'h7;
  localparam int NUM_COMPANIONS = 5;

  // ****************************************************************
  // Register space and reset values
  // ****************************************************************
  localparam int ADDR_BITS = 8;
  localparam int NUM_REGS = 256;
  localparam logic [7:0] STATUS_ADDR = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] ADDR_TOP_RESET = 3'h6;
  localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
  localparam logic [4:0] CS_N_RESET = 5'h1F;

  // ****************************************************************
  // Access sequencer states, Gray coded along idle, access, hold
  // ****************************************************************
  typedef enum logic [1:0] {
    HRP_IDLE = 2'b00,
    HRP_ACCESS = 2'b01,
    HRP_HOLD = 2'b11
  } hrp_state_e;
endpackage
`default_nettype wire

// [tb/hrp_host_model.sv]
// Host processor model that drives the parallel register port.
`default_nettype none
module hrp_host_model (
  // Clock and device answers
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic cycle_done_n,
  // Host drive
  output logic [10:0] addr_in,
  output logic address_latch_strobe,
  output logic chip_sel_n,
  output logic rd_strobe_n,
  output logic wr_dir,
  output logic sync_clk_in,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Raising the host clock a cycle early puts its rising edge before the strobes, so no access starts.
  logic sync_hold = 1'b0;

  initial
  begin
    addr_in = 11'h600;
    address_latch_strobe = 1'b0;
    chip_sel_n = 1'b1;
    rd_strobe_n = 1'b1;
    wr_dir = 1'b1;
    sync_clk_in = 1'b0;
    data_in = 8'h5A;
  end

  // ************************************************************
  // One byte transfer
  // ************************************************************
  // The address is scrambled once the strobe falls, so only a real latch sees it.
  task automatic access(input logic [2:0] st, input logic wr, input logic [10:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    q = 8'h00;
    ok = 1'b0;
    @(negedge clk);
    addr_in = a;
    address_latch_strobe = 1'b1;
    chip_sel_n = 1'b0;
    sync_clk_in = sync_hold;
    @(negedge clk);
    address_latch_strobe = 1'b0;
    addr_in = ~a;
    data_in = d;
    rd_strobe_n = (st == 3'h0) ? wr : 1'b0;
    wr_dir = ~wr;
    sync_clk_in = 1'b1;
    for (int n = 0; n < 12 && !ok; n++)
    begin
      @(posedge clk);
      if (cycle_done_n === 1'b0)
      begin
        ok = 1'b1;
        q = data_out;
      end
    end
    @(negedge clk);
    chip_sel_n = 1'b1;
    rd_strobe_n = 1'b1;
    wr_dir = 1'b1;
    sync_clk_in = 1'b0;
    data_in = ~d;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// [tb/test_host_register_port.sv]
// Self-checking bench of the parallel host register port.
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_host_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, address_latch_strobe, chip_sel_n, rd_strobe_n, wr_dir, sync_clk_in;
  logic data_oe, cycle_done_n, host_irq_n, cfg_wr_pulse, ok;
  logic [2:0] host_style_select;
  logic [10:0] addr_in;
  logic [7:0] data_in, data_out, status_in, cfg_wr_addr, cfg_wr_data, last_a, last_d, q;
  logic [4:0] companion_cs_n;
  logic [7:0] mem [256];
  logic [7:0] addrs [6];
  logic [31:0] seed = 32'h0000_0015;
  int error_cnt = 0;
  int samples_checked = 0;
  int oe_cnt = 0;

  hrp_host_port u_dut (.clk(clk), .rst(rst), .host_style_select(host_style_select),
    .addr_in(addr_in), .address_latch_strobe(address_latch_strobe), .chip_sel_n(chip_sel_n),
    .rd_strobe_n(rd_strobe_n), .wr_dir(wr_dir), .sync_clk_in(sync_clk_in),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .cycle_done_n(cycle_done_n),
    .host_irq_n(host_irq_n), .companion_cs_n(companion_cs_n), .status_in(status_in),
    .cfg_wr_pulse(cfg_wr_pulse), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data));
  hrp_host_model host (.clk(clk), .data_out(data_out), .cycle_done_n(cycle_done_n),
    .addr_in(addr_in), .address_latch_strobe(address_latch_strobe), .chip_sel_n(chip_sel_n),
    .rd_strobe_n(rd_strobe_n), .wr_dir(wr_dir), .sync_clk_in(sync_clk_in),
    .data_in(data_in));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [4:0] exp_cs(input logic [2:0] t);
    if (t == 3'h7)
      return 5'h00;
    if (t == 3'h0 || t == 3'h6)
      return 5'h1F;
    return ~(5'h01 << (t - 3'h1));
  endfunction

  always @(posedge clk)
  begin
    if (cfg_wr_pulse === 1'b1)
    begin
      last_a <= cfg_wr_addr;
      last_d <= cfg_wr_data;
    end
    if (data_oe === 1'b1)
    begin
      oe_cnt++;
      `CHK({cycle_done_n, wr_dir}, 2'b01)
    end
  end

  task automatic do_reset(input logic [2:0] st);
    @(negedge clk);
    host_style_select = st;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(negedge clk);
    `CHK({data_oe, cycle_done_n, host_irq_n, companion_cs_n}, 8'h7F)
  endtask

  task automatic run_rw(input logic [2:0] st);
    logic [31:0] r;
    int n0;
    for (int i = 0; i < 6; i++)
    begin
      r = xs();
      addrs[i] = (r[7:0] == 8'hFF) ? 8'hFE : r[7:0];
      host.access(st, 1'b1, {3'h0, addrs[i]}, r[15:8], q, ok);
      `CHK({ok, last_a, last_d}, {1'b1, addrs[i], r[15:8]})
      mem[addrs[i]] = r[15:8];
    end
    for (int i = 0; i < 6; i++)
    begin
      n0 = oe_cnt;
      host.access(st, 1'b0, {3'h0, addrs[i]}, 8'h00, q, ok);
      `CHK({ok, q}, {1'b1, mem[addrs[i]]})
      `CHK(oe_cnt - n0, 2)
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    rst = 1'b1;
    host_style_select = 3'h0;
    status_in = 8'h00;
    foreach (addrs[k]) run_rw_style(k);
    for (int t = 0; t < 8; t++)
    begin
      fork
        host.access(3'h7, 1'b1, {t[2:0], 8'h30 ^ t[7:0]}, 8'hC3 ^ t[7:0], q, ok);
        begin
          repeat (4) @(negedge clk);
          `CHK(companion_cs_n, exp_cs(t[2:0]))
        end
      join
      `CHK(ok, t == 0 || t == 7)
      if (ok)
        mem[8'h30 ^ t[7:0]] = 8'hC3 ^ t[7:0];
      host.access(3'h7, 1'b0, {3'h0, 8'h30 ^ t[7:0]}, 8'h00, q, ok);
      `CHK(q, mem[8'h30 ^ t[7:0]])
    end
    host.access(3'h7, 1'b0, 11'h730, 8'h00, q, ok);
    `CHK(ok, 1'b0)
    status_in = 8'h40;
    repeat (2) @(negedge clk);
    `CHK(host_irq_n, 1'b0)
    host.access(3'h7, 1'b0, 11'h0FF, 8'h00, q, ok);
    `CHK(q, 8'h40)
    status_in = 8'h00;
    host.sync_hold = 1'b1;
    host.access(3'h7, 1'b1, 11'h012, 8'h77, q, ok);
    `CHK(ok, 1'b0)
    host.sync_hold = 1'b0;
    host.access(3'h7, 1'b0, 11'h012, 8'h00, q, ok);
    `CHK({ok, q}, {1'b1, mem[8'h12]})
    do_reset(3'h3);
    host.access(3'h3, 1'b1, 11'h011, 8'h99, q, ok);
    `CHK(ok, 1'b0)
    tally_and_finish();
  end

  task automatic run_rw_style(input int k);
    logic [2:0] st;
    st = (k == 0) ? 3'h0 : ((k == 1) ? 3'h1 : 3'h7);
    if (k < 3)
    begin
      do_reset(st);
      run_rw(st);
    end
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
